// ### include/flash_timing_pkg.sv
// Purpose: shared constants for the serial flash timing link
// Assumes: core clock of 50 MHz on both ends
// Notes: times are kept in ns, cycle counts are derived from them
package flash_timing_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CLK_MHZ = 1000 / CLK_PERIOD_NS;

  // longest times round down, least times round up, never below one cycle
  function automatic int unsigned cyc_floor(input longint unsigned ns);
    longint unsigned c;
    c = ns / CLK_PERIOD_NS;
    return (c == 0) ? 32'd1 : 32'(c);
  endfunction

  function automatic int unsigned cyc_ceil(input longint unsigned ns);
    longint unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c == 0) ? 32'd1 : 32'(c);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // command codes (arbitrary encodings of this link)
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h11;
  localparam logic [7:0] CMD_READ_STATUS = 8'h12;
  localparam logic [7:0] CMD_PAGE_PROG = 8'h13;
  localparam logic [7:0] CMD_BYTE_PROG = 8'h14;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h15;
  localparam logic [7:0] CMD_BLOCK32_ERASE = 8'h16;
  localparam logic [7:0] CMD_BLOCK64_ERASE = 8'h17;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h18;
  localparam logic [7:0] CMD_SUSPEND = 8'h19;
  localparam logic [7:0] CMD_RESUME = 8'h1A;
  localparam logic [7:0] CMD_DEEP_PD = 8'h1B;
  localparam logic [7:0] CMD_RELEASE = 8'h1C;

  localparam int unsigned CNT_W = 5;
  // clock_i edges from a chip-select rise to the device core acting on the frame
  localparam int unsigned SYNC_LAT_CYC = 3;
  localparam logic [4:0] OP_BITS = 5'd8;
  localparam logic [4:0] RD_BITS = 5'd16;
  localparam logic [4:0] SW_BITS = 5'd24;

  // status and configuration fields
  localparam int unsigned STAT_WIP_BIT = 0;
  localparam int unsigned STAT_SWD_BIT = 7;
  localparam int unsigned CFG_PERF_BIT = 1;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h02;
  localparam logic [7:0] CFG_PERF_MASK = 8'h02;

  ////////////////////////////////////////////////////////////////////////////
  // times in ns, high-performance mode
  localparam longint unsigned SUSPEND_LAT_MAX_NS = 64'd40_000;
  localparam longint unsigned RESUME_SPACING_MIN_NS = 64'd300;
  localparam longint unsigned PROG_PROGRESS_NS = 64'd100_000;
  localparam longint unsigned ERASE_PROGRESS_NS = 64'd280_000;
  localparam longint unsigned DP_ENTRY_MAX_NS = 64'd10_000;
  localparam longint unsigned DP_RELEASE_MIN_NS = 64'd30_000;
  localparam longint unsigned CS_TOGGLE_MIN_NS = 64'd20;
  localparam longint unsigned DP_RECOVER_MIN_NS = 64'd45_000;
  localparam longint unsigned CS_HIGH_MIN_NS = 64'd30;
  localparam longint unsigned STATUS_WRITE_TYP_NS = 64'd9_500_000;
  localparam longint unsigned MODE_SWITCH_MAX_NS = 64'd20_000;
  localparam longint unsigned PAGE_PROG_TYP_NS = 64'd850_000;
  localparam longint unsigned PAGE_PROG_HV_TYP_NS = 64'd600_000;
  localparam longint unsigned BYTE_PROG_TYP_NS = 64'd32_000;
  localparam longint unsigned SECTOR_TYP_NS = 64'd40_000_000;
  localparam longint unsigned SECTOR_HV_TYP_NS = 64'd36_000_000;
  localparam longint unsigned BLOCK32_TYP_NS = 64'd240_000_000;
  localparam longint unsigned BLOCK32_HV_TYP_NS = 64'd220_000_000;
  localparam longint unsigned BLOCK64_TYP_NS = 64'd480_000_000;
  localparam longint unsigned BLOCK64_HV_TYP_NS = 64'd430_000_000;
  localparam longint unsigned CHIP_TYP_NS = 64'd13_000_000_000;
  localparam longint unsigned CHIP_HV_TYP_NS = 64'd12_000_000_000;
  localparam int unsigned STATUS_WRITE_MAX_MHZ = 33;

  // short counts, all below 4096 cycles
  localparam int unsigned DLY_W = 12;
  localparam int unsigned SUSPEND_LAT_CYC = cyc_floor(SUSPEND_LAT_MAX_NS);
  localparam int unsigned DP_ENTRY_CYC = cyc_floor(DP_ENTRY_MAX_NS);
  localparam int unsigned DP_RELEASE_CYC = cyc_ceil(DP_RELEASE_MIN_NS);
  localparam int unsigned DP_RECOVER_CYC = cyc_ceil(DP_RECOVER_MIN_NS);
  localparam int unsigned MODE_SWITCH_CYC = cyc_floor(MODE_SWITCH_MAX_NS);
  localparam int unsigned BYTE_PROG_CYC = cyc_floor(BYTE_PROG_TYP_NS);
  localparam int unsigned CS_HIGH_CYC = cyc_ceil(CS_HIGH_MIN_NS);
  // extra cycles so the far end's two-flop synchroniser sees the low level
  localparam int unsigned CS_TOGGLE_CYC = cyc_ceil(CS_TOGGLE_MIN_NS) + 3;
  localparam int unsigned MIN_HALF_SW =
    (CLK_MHZ + 2 * STATUS_WRITE_MAX_MHZ - 1) / (2 * STATUS_WRITE_MAX_MHZ);

endpackage

// ### include/flash_link_if.sv
// Purpose: serial link between flash controller and flash device
// Assumes: mode 0 framing, device samples si on sclk rise
// Notes: all wires are one-way, no pin is shared
`timescale 1ns/100ps
interface flash_link_if;
  logic cs_n;
  logic sclk;
  logic si;
  logic so;
  logic wp_n;
  logic wp_hv;

  modport host (output cs_n, output sclk, output si, output wp_n, output wp_hv, input so);
  modport flash (input cs_n, input sclk, input si, input wp_n, input wp_hv, output so);
endinterface

// ### design/flash_device_end.sv
// Purpose: timing behaviour of a serial flash in high-performance mode
// Assumes: link side runs on sclk, internal timers on clock_i
// Notes: operations are timed by clock_i, never by the serial clock
// Behaviour
// - timings hold with performance bit set
// - suspend halts and clears busy within 40us
// - host waits 0.3us from program resume
// - host allows 100us program resume-to-suspend
// - erase resume spacing 0.3us, progress 280us
// - deep power-down reached within 10us
// - host waits 30us before release
// - release chip-select low at least 20ns
// - 45us recovery, no command meanwhile
// - status write finishes within 20ms
// - mode-only status write within 20us
// - status write mode switch at most 33MHz
// - quad reads reissued each 4Mb boundary; this model has no quad read command
// - write-protect setup/hold when disable bit set
// - page program within 4ms, 3.6ms high-voltage
// - byte program within 100us
// - sector erase within 240ms, 210ms high-voltage
// - 32KB erase within 1.5s, 1.05s high-voltage
// - 64KB erase within 3s, 2.1s high-voltage
// - chip erase within 38s, 34s high-voltage
`timescale 1ns/100ps
module flash_device_end
  import flash_timing_pkg::*;
#(
  // busy cycles: page, sector, 32KB, 64KB, chip; each normal then high voltage
  parameter int unsigned T_MEM [10] = '{cyc_floor(PAGE_PROG_TYP_NS),
    cyc_floor(PAGE_PROG_HV_TYP_NS), cyc_floor(SECTOR_TYP_NS), cyc_floor(SECTOR_HV_TYP_NS),
    cyc_floor(BLOCK32_TYP_NS), cyc_floor(BLOCK32_HV_TYP_NS), cyc_floor(BLOCK64_TYP_NS),
    cyc_floor(BLOCK64_HV_TYP_NS), cyc_floor(CHIP_TYP_NS), cyc_floor(CHIP_HV_TYP_NS)},
  parameter int unsigned T_STATUS_WRITE = cyc_floor(STATUS_WRITE_TYP_NS)
) (
  // core clock, reset and enable
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // serial link
  flash_link_if.flash link,
  // device state
  output logic wip_o,
  output logic suspended_o,
  output logic deep_pd_o,
  output logic perf_mode_o
);

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_BUSY = 7'h02,
    ST_HALTING = 7'h04,
    ST_SUSPENDED = 7'h08,
    ST_DP_ENTER = 7'h10,
    ST_DP = 7'h20,
    ST_RECOVER = 7'h40
  } dev_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: shift in command, shift out status
  logic [CNT_W-1:0] bit_cnt;
  logic [23:0] shreg;
  logic [7:0] op_word;
  logic [15:0] arg_word;
  logic args_ok;
  logic op_tog;
  logic so_q;
  logic [7:0] stat_m;
  logic [7:0] stat_s;
  logic [7:0] status_byte;

  wire [23:0] shreg_in = {shreg[22:0], link.si};
  wire rd_active = (op_word == CMD_READ_STATUS) && (bit_cnt >= OP_BITS) && (bit_cnt < RD_BITS);
  wire [2:0] rd_idx = ~bit_cnt[2:0];

  // the frame counter restarts whenever chip select is high
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt <= '0;
    end else if (bit_cnt != SW_BITS) begin
      bit_cnt <= bit_cnt + 5'd1;
    end
  end

  always_ff @(posedge link.sclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shreg <= '0;
      op_word <= '0;
      arg_word <= '0;
      args_ok <= 1'b0;
      op_tog <= 1'b0;
      stat_m <= '0;
      stat_s <= '0;
    end else begin
      shreg <= shreg_in;
      stat_m <= status_byte;
      stat_s <= stat_m;
      if (bit_cnt == OP_BITS - 5'd1) begin
        op_word <= shreg_in[7:0];
        args_ok <= 1'b0;
        op_tog <= ~op_tog;
      end
      if (bit_cnt == SW_BITS - 5'd1) begin
        arg_word <= shreg_in[15:0];
        args_ok <= 1'b1;
      end
    end
  end

  always_ff @(negedge link.sclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      so_q <= 1'b0;
    end else begin
      so_q <= rd_active & stat_s[rd_idx];
    end
  end

  assign link.so = so_q;

  ////////////////////////////////////////////////////////////////////////////
  // core domain: synchronisers
  logic cs_m, cs_s, cs_q;
  logic tog_m, tog_s, tog_seen;
  logic hv_m, hv_s;
  logic wpn_m, wpn_s;

  // op_word, arg_word and args_ok are still by the time a frame end is seen
  wire frame_end = cs_s & ~cs_q;
  wire cs_fall = ~cs_s & cs_q;
  wire new_cmd = frame_end & (tog_s != tog_seen);

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_q <= 1'b1;
      tog_m <= 1'b0;
      tog_s <= 1'b0;
      tog_seen <= 1'b0;
      hv_m <= 1'b0;
      hv_s <= 1'b0;
      wpn_m <= 1'b1;
      wpn_s <= 1'b1;
    end else if (ce_i) begin
      cs_m <= link.cs_n;
      cs_s <= cs_m;
      cs_q <= cs_s;
      tog_m <= op_tog;
      tog_s <= tog_m;
      hv_m <= link.wp_hv;
      hv_s <= hv_m;
      wpn_m <= link.wp_n;
      wpn_s <= wpn_m;
      if (frame_end) begin
        tog_seen <= tog_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operation decode and durations
  dev_state_e state, next_state;
  logic [31:0] op_left, next_left;
  logic [DLY_W-1:0] dly, next_dly;
  logic busy_mem, next_mem;
  logic [7:0] status_reg, next_status;
  logic [7:0] cfg_reg, next_cfg;
  logic next_wip;

  assign status_byte = {status_reg[7:1], wip_o};

  wire is_page = op_word == CMD_PAGE_PROG;
  wire is_byte = op_word == CMD_BYTE_PROG;
  wire is_sector = op_word == CMD_SECTOR_ERASE;
  wire is_blk32 = op_word == CMD_BLOCK32_ERASE;
  wire is_blk64 = op_word == CMD_BLOCK64_ERASE;
  wire is_chip = op_word == CMD_CHIP_ERASE;
  wire is_mem_op = is_page | is_byte | is_sector | is_blk32 | is_blk64 | is_chip;
  wire do_mem = new_cmd & is_mem_op;
  wire do_suspend = new_cmd & (op_word == CMD_SUSPEND) & busy_mem;
  wire do_resume = new_cmd & (op_word == CMD_RESUME);
  wire do_dp = new_cmd & (op_word == CMD_DEEP_PD);

  // write protect low with the disable bit set refuses the status write
  wire sw_blocked = status_reg[STAT_SWD_BIT] & ~wpn_s;
  wire do_sw = new_cmd & (op_word == CMD_STATUS_WRITE) & args_ok & ~sw_blocked;
  wire [7:0] sw_status = arg_word[15:8];
  wire [7:0] sw_cfg = arg_word[7:0];
  wire mode_only = (sw_status[7:1] == status_reg[7:1]) && ((sw_cfg ^ cfg_reg) == CFG_PERF_MASK);
  wire [31:0] sw_cycles = mode_only ? MODE_SWITCH_CYC : T_STATUS_WRITE;

  // all figures are the high-performance ones; the same set is used in low-power mode
  wire [31:0] mem_cycles =
    is_page ? (hv_s ? T_MEM[1] : T_MEM[0]) :
    is_byte ? BYTE_PROG_CYC :
    is_sector ? (hv_s ? T_MEM[3] : T_MEM[2]) :
    is_blk32 ? (hv_s ? T_MEM[5] : T_MEM[4]) :
    is_blk64 ? (hv_s ? T_MEM[7] : T_MEM[6]) :
    (hv_s ? T_MEM[9] : T_MEM[8]);

  ////////////////////////////////////////////////////////////////////////////
  // operation state machine
  always_comb begin
    next_state = state;
    next_left = op_left;
    next_dly = dly;
    next_mem = busy_mem;
    next_status = status_reg;
    next_cfg = cfg_reg;
    next_wip = wip_o;
    case (state)
      ST_IDLE: begin
        if (do_mem) begin
          next_state = ST_BUSY;
          next_left = mem_cycles;
          next_mem = 1'b1;
          next_wip = 1'b1;
        end else if (do_sw) begin
          next_state = ST_BUSY;
          next_left = sw_cycles;
          next_mem = 1'b0;
          next_status = sw_status;
          next_cfg = sw_cfg;
          next_wip = 1'b1;
        end else if (do_dp) begin
          next_state = ST_DP_ENTER;
          next_dly = DLY_W'(DP_ENTRY_CYC - SYNC_LAT_CYC);
        end
      end
      ST_BUSY: begin
        if (do_suspend) begin
          next_state = ST_HALTING;
          next_dly = DLY_W'(SUSPEND_LAT_CYC - SYNC_LAT_CYC);
        end else if (op_left <= 32'd1) begin
          next_state = ST_IDLE;
          next_wip = 1'b0;
        end else begin
          next_left = op_left - 32'd1;
        end
      end
      ST_HALTING: begin
        if (dly <= DLY_W'(1)) begin
          next_state = ST_SUSPENDED;
          next_wip = 1'b0;
        end else begin
          next_dly = dly - DLY_W'(1);
        end
      end
      ST_SUSPENDED: begin
        // the remaining count was frozen, so progress needs long resume spans
        if (do_resume) begin
          next_state = ST_BUSY;
          next_wip = 1'b1;
        end
      end
      ST_DP_ENTER: begin
        if (dly <= DLY_W'(1)) begin
          next_state = ST_DP;
        end else begin
          next_dly = dly - DLY_W'(1);
        end
      end
      ST_DP: begin
        // any chip-select low period wakes the device; commands are ignored
        if (cs_fall) begin
          next_state = ST_RECOVER;
          next_dly = DLY_W'(DP_RECOVER_CYC);
        end
      end
      ST_RECOVER: begin
        if (dly <= DLY_W'(1)) begin
          next_state = ST_IDLE;
        end else begin
          next_dly = dly - DLY_W'(1);
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_wip = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      op_left <= '0;
      dly <= '0;
      busy_mem <= 1'b0;
      status_reg <= STATUS_RST;
      cfg_reg <= CFG_RST;
      wip_o <= 1'b0;
      suspended_o <= 1'b0;
      deep_pd_o <= 1'b0;
      perf_mode_o <= CFG_RST[CFG_PERF_BIT];
    end else if (ce_i) begin
      state <= next_state;
      op_left <= next_left;
      dly <= next_dly;
      busy_mem <= next_mem;
      status_reg <= next_status;
      cfg_reg <= next_cfg;
      wip_o <= next_wip;
      suspended_o <= next_state == ST_SUSPENDED;
      deep_pd_o <= next_state == ST_DP;
      perf_mode_o <= next_cfg[CFG_PERF_BIT];
    end
  end

endmodule

// ### design/flash_host_end.sv
// Purpose: flash controller issuing timed commands over the serial link
// Assumes: serial clock made here by dividing clock_i
// Notes: requests wait until every spacing the device needs has passed
`timescale 1ns/100ps
module flash_host_end
  import flash_timing_pkg::*;
#(
  parameter int unsigned SCLK_HALF = 4,
  parameter int unsigned PROG_SPACING_CYC = cyc_ceil(PROG_PROGRESS_NS),
  parameter int unsigned ERASE_SPACING_CYC = cyc_ceil(ERASE_PROGRESS_NS)
) (
  // clock, reset and enable
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // request
  input wire logic req_valid_i,
  input wire logic [7:0] req_op_i,
  input wire logic [15:0] req_arg_i,
  output logic req_ready_o,
  // answer
  output logic done_o,
  output logic [7:0] status_o,
  // write-protect controls
  input wire logic wp_n_i,
  input wire logic wp_hv_i,
  // serial link
  flash_link_if.host link
);

  localparam int unsigned SW_HALF = (SCLK_HALF > MIN_HALF_SW) ? SCLK_HALF : MIN_HALF_SW;
  localparam int unsigned G_W = 16;

  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_WAIT = 5'h02,
    H_SHIFT = 5'h04,
    H_PULSE = 5'h08,
    H_GAP = 5'h10
  } host_state_e;

  host_state_e state;
  logic [7:0] op;
  logic [23:0] tx;
  logic [7:0] rx;
  logic [CNT_W-1:0] bits;
  logic [7:0] ph;
  logic [G_W-1:0] cmd_guard;
  logic [G_W-1:0] susp_guard;
  logic erase_kind;
  logic cs_q, sclk_q, si_q, wpn_q, hv_q;
  logic so_m, so_s;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire is_sw = op == CMD_STATUS_WRITE;
  wire is_rd = op == CMD_READ_STATUS;
  wire is_susp = op == CMD_SUSPEND;
  wire is_resume = op == CMD_RESUME;
  wire is_dp = op == CMD_DEEP_PD;
  wire is_release = op == CMD_RELEASE;
  wire is_prog = (op == CMD_PAGE_PROG) | (op == CMD_BYTE_PROG);
  wire is_erase = (op == CMD_SECTOR_ERASE) | (op == CMD_BLOCK32_ERASE) |
                  (op == CMD_BLOCK64_ERASE) | (op == CMD_CHIP_ERASE);
  // mode switches go out at no more than the status-write rate
  wire [7:0] half_m1 = is_sw ? 8'(SW_HALF - 1) : 8'(SCLK_HALF - 1);
  wire [CNT_W-1:0] nbits = is_sw ? SW_BITS : (is_rd ? RD_BITS : OP_BITS);
  wire guards_clear = (cmd_guard == '0) && (!is_susp || susp_guard == '0);
  wire ph_end = ph == half_m1;
  wire [G_W-1:0] resume_gap = erase_kind ? G_W'(ERASE_SPACING_CYC) : G_W'(PROG_SPACING_CYC);

  assign link.cs_n = cs_q;
  assign link.sclk = sclk_q;
  assign link.si = si_q;
  assign link.wp_n = wpn_q;
  assign link.wp_hv = hv_q;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state <= H_IDLE;
      op <= '0;
      tx <= '0;
      rx <= '0;
      bits <= '0;
      ph <= '0;
      cmd_guard <= '0;
      susp_guard <= '0;
      erase_kind <= 1'b0;
      cs_q <= 1'b1;
      sclk_q <= 1'b0;
      si_q <= 1'b0;
      wpn_q <= 1'b1;
      hv_q <= 1'b0;
      so_m <= 1'b0;
      so_s <= 1'b0;
      req_ready_o <= 1'b0;
      done_o <= 1'b0;
      status_o <= '0;
    end else if (ce_i) begin
      so_m <= link.so;
      so_s <= so_m;
      done_o <= 1'b0;
      if (cmd_guard != '0) begin
        cmd_guard <= cmd_guard - G_W'(1);
      end
      if (susp_guard != '0) begin
        susp_guard <= susp_guard - G_W'(1);
      end
      case (state)
        H_IDLE: begin
          // pins change only between frames, keeping set-up and hold around them
          wpn_q <= wp_n_i;
          hv_q <= wp_hv_i;
          req_ready_o <= ~req_valid_i;
          if (req_valid_i && req_ready_o) begin
            op <= req_op_i;
            tx <= {req_op_i, req_arg_i};
            state <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (guards_clear) begin
            cs_q <= 1'b0;
            ph <= '0;
            state <= is_release ? H_PULSE : H_SHIFT;
            si_q <= tx[23];
            bits <= nbits;
            if (is_prog) erase_kind <= 1'b0;
            if (is_erase) erase_kind <= 1'b1;
            if (is_resume) susp_guard <= resume_gap;
          end
        end
        H_SHIFT: begin
          ph <= ph_end ? 8'h00 : ph + 8'h01;
          if (ph_end) begin
            sclk_q <= ~sclk_q;
            if (sclk_q) begin
              rx <= {rx[6:0], so_s};
              tx <= {tx[22:0], 1'b0};
              si_q <= tx[22];
              bits <= bits - 5'd1;
              if (bits == 5'd1) begin
                cs_q <= 1'b1;
                state <= H_GAP;
                if (is_rd) status_o <= {rx[6:0], so_s};
                if (is_dp) cmd_guard <= G_W'(DP_RELEASE_CYC);
              end
            end
          end
        end
        H_PULSE: begin
          ph <= ph + 8'h01;
          if (ph == 8'(CS_TOGGLE_CYC - 1)) begin
            cs_q <= 1'b1;
            ph <= '0;
            state <= H_GAP;
            cmd_guard <= G_W'(DP_RECOVER_CYC);
          end
        end
        H_GAP: begin
          ph <= ph + 8'h01;
          if (ph == 8'(CS_HIGH_CYC - 1)) begin
            ph <= '0;
            state <= H_IDLE;
            done_o <= 1'b1;
            req_ready_o <= 1'b1;
          end
        end
        default: begin
          state <= H_IDLE;
          cs_q <= 1'b1;
        end
      endcase
    end
  end

endmodule

// ### testbench/flash_link_asserts.sv
// Purpose: wire-level timing checks on the flash link
// Assumes: cs_n and sclk are flops of the host's clock_i
// Notes: frames are decoded on clock_i; a frame without clocks is the wake pulse
`timescale 1ns/100ps
module flash_link_asserts
  import flash_timing_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // link wires
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic so,
  input wire logic wp_n,
  input wire logic wp_hv,
  // device state
  input wire logic wip_o,
  input wire logic deep_pd_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  logic sclk_q;
  logic cs_q;
  logic [7:0] shift;
  logic [4:0] nbits;
  logic [7:0] last_op;
  logic [15:0] since;
  wire sclk_rise = sclk && !sclk_q;
  wire frame_end = cs_n && !cs_q;
  wire [7:0] frame_op = (nbits >= 5'h08) ? shift : CMD_RELEASE;
  // status polls must not restart the timing of the operation they watch
  wire track = frame_end && (frame_op != CMD_READ_STATUS);
  wire [4:0] next_nbits = cs_n ? 5'h00 : nbits + {4'h0, sclk_rise && nbits != 5'h1F};
  wire [7:0] next_shift = (sclk_rise && nbits < 5'h08) ? {shift[6:0], si} : shift;
  wire [15:0] next_since = track ? 16'h0000 : since + {15'h0, since != 16'hFFFF};
  always_ff @(posedge clock_i) begin
    sclk_q <= rst_n_i ? sclk : 1'b0;
    cs_q <= rst_n_i ? cs_n : 1'b1;
    nbits <= rst_n_i ? next_nbits : 5'h00;
    shift <= rst_n_i ? next_shift : 8'h00;
    last_op <= !rst_n_i ? 8'h00 : (track ? frame_op : last_op);
    since <= rst_n_i ? next_since : 16'hFFFF;
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_suspend_latency;
    wip_o && last_op == CMD_SUSPEND |-> since <= 16'h07D0;
  endproperty
  a_suspend_latency: assert property (p_suspend_latency)
    else $error("busy held too long after suspend");
  property p_dp_entry;
    last_op == CMD_DEEP_PD && cs_n && !frame_end && since >= 16'h01F4 |-> deep_pd_o;
  endproperty
  a_dp_entry: assert property (p_dp_entry)
    else $error("deep power-down not reached in time");
  property p_release_wait;
    $fell(cs_n) && last_op == CMD_DEEP_PD |-> since >= DP_RELEASE_CYC;
  endproperty
  a_release_wait: assert property (p_release_wait)
    else $error("release issued too early");
  property p_recovery;
    $fell(cs_n) && last_op == CMD_RELEASE |-> since >= DP_RECOVER_CYC;
  endproperty
  a_recovery: assert property (p_recovery)
    else $error("command issued during recovery");
  property p_release_pulse;
    $fell(cs_n) |=> !cs_n;
  endproperty
  a_release_pulse: assert property (p_release_pulse)
    else $error("chip select low too short");
  property p_sclk_rate;
    !cs_n && $changed(sclk) |=> $stable(sclk)[*3];
  endproperty
  a_sclk_rate: assert property (p_sclk_rate)
    else $error("serial clock too fast");
  property p_byte_max;
    wip_o && last_op == CMD_BYTE_PROG |-> since <= 16'h1388;
  endproperty
  a_byte_max: assert property (p_byte_max)
    else $error("byte program too long");
  property p_byte_span;
    $fell(wip_o) && last_op == CMD_BYTE_PROG |-> since >= BYTE_PROG_CYC;
  endproperty
  a_byte_span: assert property (p_byte_span)
    else $error("busy dropped before byte program ended");
  c_suspend: cover property (frame_end && frame_op == CMD_SUSPEND);
  c_dp: cover property ($rose(deep_pd_o));
  c_wake: cover property (frame_end && frame_op == CMD_RELEASE);
endmodule

// ### testbench/serial_flash_operation_timing_tb.sv
// Purpose: host end and device end joined, driven through host requests
// Assumes: device page, erase and full status-write busy counts shortened by parameters; byte program and mode switch keep theirs
// Notes: busy spans are measured on wip_o, spacings by cycle stamps
`timescale 1ns/100ps
module serial_flash_operation_timing_tb;
  import flash_timing_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic [7:0] req_op_i = 8'h00;
  logic [15:0] req_arg_i = 16'h0000;
  logic wp_n_i = 1'b1;
  logic wp_hv_i = 1'b0, ce_i = 1'b1;
  logic req_ready_o, done_o, wip_o, suspended_o, deep_pd_o, perf_mode_o;
  logic [7:0] status_o;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0, n, t0;
  logic [7:0] ops [12] = '{CMD_PAGE_PROG, CMD_PAGE_PROG, CMD_SECTOR_ERASE, CMD_SECTOR_ERASE,
    CMD_BLOCK32_ERASE, CMD_BLOCK32_ERASE, CMD_BLOCK64_ERASE, CMD_BLOCK64_ERASE,
    CMD_CHIP_ERASE, CMD_CHIP_ERASE, CMD_BYTE_PROG, CMD_BYTE_PROG};
  int lens [12] = '{200, 150, 200, 180, 120, 110, 160, 140, 190, 170, 1600, 1600};
  flash_link_if link ();
  always #10 clock_i = ~clock_i;
  always @(posedge clock_i) cyc++;
  flash_host_end #(.PROG_SPACING_CYC(20), .ERASE_SPACING_CYC(20)) flash_host_end_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .req_valid_i(req_valid_i),
    .req_op_i(req_op_i), .req_arg_i(req_arg_i), .req_ready_o(req_ready_o), .done_o(done_o),
    .status_o(status_o), .wp_n_i(wp_n_i), .wp_hv_i(wp_hv_i), .link(link));
  flash_device_end #(.T_MEM('{200, 150, 200, 180, 120, 110, 160, 140, 190, 170}),
    .T_STATUS_WRITE(200)) flash_device_end_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .link(link), .wip_o(wip_o),
    .suspended_o(suspended_o), .deep_pd_o(deep_pd_o), .perf_mode_o(perf_mode_o));
  flash_link_asserts flash_link_asserts_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .cs_n(link.cs_n), .sclk(link.sclk), .si(link.si), .so(link.so), .wp_n(link.wp_n),
    .wp_hv(link.wp_hv), .wip_o(wip_o), .deep_pd_o(deep_pd_o));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held from just after an edge until ready is sampled high
  task automatic issue(input logic [7:0] op, input logic [15:0] arg);
    int k;
    @(posedge clock_i);
    #1 req_valid_i = 1'b1;
    req_op_i = op;
    req_arg_i = arg;
    k = 0;
    do begin @(posedge clock_i); k++; end while (req_ready_o !== 1'b1 && k < 9000);
    #1 req_valid_i = 1'b0;
    for (k = 0; k < 9000 && done_o !== 1'b1; k++) begin @(posedge clock_i); #1; end
    chk(done_o, 16'h0001);
  endtask
  task automatic busy_len(output int m);
    for (m = 0; m < 10 && wip_o !== 1'b1; m++) @(posedge clock_i);
    for (m = 0; m < 9000 && wip_o === 1'b1; m++) @(posedge clock_i);
  endtask
  task automatic t_suspend(input logic [7:0] op);
    issue(op, 16'h0000);
    issue(CMD_SUSPEND, 16'h0000);
    repeat (2000) @(posedge clock_i);
    #1 chk({wip_o, suspended_o}, 16'h0001);
    t0 = cyc;
    issue(CMD_RESUME, 16'h0000);
    issue(CMD_SUSPEND, 16'h0000);
    chk(cyc - t0 >= 15, 16'h0001);
    repeat (2000) @(posedge clock_i);
    issue(CMD_RESUME, 16'h0000);
    busy_len(n);
    chk({wip_o, suspended_o}, 16'h0000);
  endtask
  task automatic t_deep_pd();
    issue(CMD_DEEP_PD, 16'h0000);
    t0 = cyc;
    repeat (520) @(posedge clock_i);
    #1 chk(deep_pd_o, 16'h0001);
    issue(CMD_RELEASE, 16'h0000);
    chk(cyc - t0 >= 1500, 16'h0001);
    t0 = cyc;
    issue(CMD_READ_STATUS, 16'h0000);
    chk(cyc - t0 >= 2240, 16'h0001);
    chk(deep_pd_o, 16'h0000);
  endtask
  task automatic t_status();
    issue(CMD_STATUS_WRITE, 16'h0000);
    busy_len(n);
    chk(n <= 1000, 16'h0001);
    chk(perf_mode_o, 16'h0000);
    issue(CMD_STATUS_WRITE, 16'h8002);
    busy_len(n);
    #1 wp_n_i = 1'b0;
    issue(CMD_STATUS_WRITE, 16'h0000);
    busy_len(n);
    chk(n, 16'h0000);
    #1 wp_n_i = 1'b1;
    issue(CMD_STATUS_WRITE, 16'h0002);
    busy_len(n);
    issue(CMD_READ_STATUS, 16'h0000);
    chk({status_o, 7'h00, perf_mode_o}, 16'h0001);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("errors=%0d checks=%0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clock_i);
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    chk({wip_o, suspended_o, deep_pd_o, perf_mode_o}, 16'h0001);
    for (int i = 0; i < 12; i++) begin
      #1 wp_hv_i = i[0];
      issue(ops[i], 16'h0000);
      busy_len(n);
      chk(n >= lens[i] - 3 && n <= lens[i] + 3, 16'h0001);
    end
    #1 wp_hv_i = 1'b0;
    issue(CMD_BYTE_PROG, 16'h0000);
    #1 ce_i = 1'b0;
    repeat (100) @(posedge clock_i);
    #1 ce_i = 1'b1;
    busy_len(n);
    chk(n >= 1597, 16'h0001);
    t_suspend(CMD_PAGE_PROG);
    t_suspend(CMD_SECTOR_ERASE);
    t_deep_pd();
    t_status();
    print_verdict();
  end
endmodule
